// ===== logic/instr_exec_defs.vh
`ifndef INSTR_EXEC_DEFS_VH
`define INSTR_EXEC_DEFS_VH

`define OFS_INSTR      12'h000
`define OFS_ACC        12'h004
`define OFS_STATUS     12'h008
`define OFS_OPTION     12'h00c
`define OFS_PC         12'h010
`define OFS_STACK_TOP  12'h014
`define OFS_FILE_BASE  12'h200

`define OP_OR_ACC      6'h04
`define OP_MOVE_FILE   6'h08
`define ENC_RET_IRQ    14'h0009
`define ENC_OPT_LOAD   14'h0062
`define ENC_NOP_MASK   14'h3f9f
`define ENC_NOP        14'h0000

`define ST_ZERO_BIT    0
`define ST_GIE_BIT     1
`define ST_BUSY_BIT    2
`define ST_ILLEGAL_BIT 3

`define OPTION_RESET   8'hff
`define RET_CYCLES     2'h2

`endif

// ===== logic/instr_decode.v
`timescale 1ns/1ps
`include "instr_exec_defs.vh"

// Pure decode of one 14-bit instruction word.
module instr_decode (
  input  wire [13:0] instr,
  output wire        is_or,
  output wire        is_move,
  output wire        is_store,
  output wire        is_ret_irq,
  output wire        is_opt_load,
  output wire        is_ret_lit,
  output wire        is_nop,
  output wire        dest_file,
  output wire [6:0]  file_addr,
  output wire [7:0]  literal
);
  assign is_or       = (instr[13:8] == `OP_OR_ACC);
  assign is_move     = (instr[13:8] == `OP_MOVE_FILE);
  assign is_store    = (instr[13:7] == 7'h01);
  assign is_ret_irq  = (instr == `ENC_RET_IRQ);
  assign is_opt_load = (instr == `ENC_OPT_LOAD);
  assign is_ret_lit  = (instr[13:10] == 4'hd);
  assign is_nop      = ((instr & `ENC_NOP_MASK) == `ENC_NOP);
  assign dest_file   = instr[7];
  assign file_addr   = instr[6:0];
  assign literal     = instr[7:0];
endmodule

// ===== logic/instruction_subset_exec.v
`timescale 1ns/1ps
`include "instr_exec_defs.vh"

// Executes one instruction per write to the instruction register. Two-cycle returns
// hold the busy bit for their second cycle; a write arriving while busy is dropped.
// The core state is visible and writable over the bus, so software can set up any
// operand before it issues an instruction and read the result back afterwards.
// There is no fetch unit: the program counter only records where a fetch would go.
module instruction_subset_exec #(
  parameter FILE_DEPTH = 128
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         busy_q,
  output reg         global_irq_enable_q
);
  localparam S_IDLE = 2'b01;
  localparam S_RET  = 2'b10;

  reg [7:0]  file_q [0:FILE_DEPTH-1];
  reg [7:0]  acc_q;
  reg [7:0]  option_q;
  reg        zero_q;
  reg        illegal_q;
  reg [12:0] pc_q;
  reg [12:0] stack_top_q;
  reg [13:0] instr_q;
  reg [1:0]  state_q;
  reg        wr_pend_q;
  reg [11:0] wr_addr_q;
  reg [1:0]  ret_cnt_q;

  wire       is_or;
  wire       is_move;
  wire       is_store;
  wire       is_ret_irq;
  wire       is_opt_load;
  wire       is_ret_lit;
  wire       is_nop;
  wire       dest_file;
  wire [6:0] fa;
  wire [7:0] lit;

  instr_decode u_dec (
    .instr       (hwdata[13:0]),
    .is_or       (is_or),
    .is_move     (is_move),
    .is_store    (is_store),
    .is_ret_irq  (is_ret_irq),
    .is_opt_load (is_opt_load),
    .is_ret_lit  (is_ret_lit),
    .is_nop      (is_nop),
    .dest_file   (dest_file),
    .file_addr   (fa),
    .literal     (lit)
  );

  function zero_of;
    input [7:0] v;
    begin
      zero_of = (v == 8'h00);
    end
  endfunction

  // The file window sits at byte 0x200; each 8-bit file register takes one word.
  function in_file_win;
    input [11:0] a;
    begin
      in_file_win = (a[11:9] == 3'h1);
    end
  endfunction

  wire        addr_ok   = hsel && hready && htrans[1];
  // A write to the instruction register executes in its data phase. While a return
  // finishes, the write is dropped rather than held, since nothing here buffers it.
  wire        exec_go   = wr_pend_q && (wr_addr_q == `OFS_INSTR) && (state_q == S_IDLE);
  // Operands come straight from the file and the accumulator, so the result is
  // written back at the same edge and every instruction except the two returns takes one cycle.
  wire [7:0]  fval      = file_q[fa];
  wire [7:0]  or_res    = acc_q | fval;
  wire        file_win  = in_file_win(wr_addr_q);
  wire [6:0]  win_idx   = wr_addr_q[8:2];
  wire [11:0] rd_addr   = haddr[11:0];

  integer i;

  // Bus front end. Reads return data one edge after the address phase and write
  // data is used one edge later still, so the slave never inserts a wait state
  // and never answers with an error.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= rd_addr;
      end
      // Read data stands for one cycle only; an idle bus reads back zero.
      hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        if (in_file_win(rd_addr)) begin
          hrdata <= {24'h000000, file_q[rd_addr[8:2]]};
        end else begin
          case (rd_addr)
            `OFS_INSTR:     hrdata <= {18'h00000, instr_q};
            `OFS_ACC:       hrdata <= {24'h000000, acc_q};
            `OFS_STATUS:    hrdata <= {28'h0000000, illegal_q, busy_q, global_irq_enable_q, zero_q};
            `OFS_OPTION:    hrdata <= {24'h000000, option_q};
            `OFS_PC:        hrdata <= {19'h00000, pc_q};
            `OFS_STACK_TOP: hrdata <= {19'h00000, stack_top_q};
            default:        hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Execution and software writes. Both need the same pending write, so in one
  // cycle either the instruction runs or a register is loaded, never both.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q               <= 8'h00;
      option_q            <= `OPTION_RESET;
      zero_q              <= 1'b0;
      illegal_q           <= 1'b0;
      pc_q                <= 13'h0000;
      stack_top_q         <= 13'h0000;
      instr_q             <= 14'h0000;
      state_q             <= S_IDLE;
      busy_q              <= 1'b0;
      ret_cnt_q           <= 2'b00;
      global_irq_enable_q <= 1'b0;
      // Clearing every file register keeps reads after reset defined, at the cost of a wide reset.
      for (i = 0; i < FILE_DEPTH; i = i + 1) begin
        file_q[i] <= 8'h00;
      end
    end else begin
      case (state_q)
        S_IDLE: begin
          if (exec_go) begin
            instr_q   <= hwdata[13:0];
            illegal_q <= 1'b0;
            // The counter steps past every one-word instruction; a return overrides it below.
            pc_q      <= pc_q + 13'h0001;
            if (is_or) begin
              if (dest_file) begin
                file_q[fa] <= or_res;
              end else begin
                acc_q <= or_res;
              end
              zero_q <= zero_of(or_res);
            end else if (is_move) begin
              // Writing back to the same register still updates the zero flag, which is
              // how software tests a register in place.
              if (dest_file) begin
                file_q[fa] <= fval;
              end else begin
                acc_q <= fval;
              end
              zero_q <= zero_of(fval);
            end else if (is_store) begin
              file_q[fa] <= acc_q;
            end else if (is_ret_irq) begin
              pc_q                <= stack_top_q;
              global_irq_enable_q <= 1'b1;
              // The pop lands now; the second cycle of the return only holds busy.
              busy_q              <= 1'b1;
              ret_cnt_q           <= `RET_CYCLES - 2'h1;
              state_q             <= S_RET;
            end else if (is_opt_load) begin
              option_q <= acc_q;
            end else if (is_ret_lit) begin
              acc_q     <= lit;
              pc_q      <= stack_top_q;
              busy_q    <= 1'b1;
              ret_cnt_q <= `RET_CYCLES - 2'h1;
              state_q   <= S_RET;
            end else if (!is_nop) begin
              // Unknown words raise a flag and step the counter like a no-op; the next executed word clears it.
              illegal_q <= 1'b1;
            end
          end else if (wr_pend_q) begin
            if (file_win) begin
              file_q[win_idx] <= hwdata[7:0];
            end else begin
              case (wr_addr_q)
                `OFS_ACC:       acc_q <= hwdata[7:0];
                `OFS_OPTION:    option_q <= hwdata[7:0];
                `OFS_PC:        pc_q <= hwdata[12:0];
                `OFS_STACK_TOP: stack_top_q <= hwdata[12:0];
                `OFS_STATUS: begin
                  zero_q              <= hwdata[`ST_ZERO_BIT];
                  global_irq_enable_q <= hwdata[`ST_GIE_BIT];
                end
                default: ;
              endcase
            end
          end
        end
        S_RET: begin
          // Second cycle of a return: the pop already happened, only time passes.
          // The stack has one entry, so the pop is a plain copy of the stack top.
          ret_cnt_q <= ret_cnt_q - 2'b01;
          if (ret_cnt_q == 2'b01) begin
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== dv/instr_exec_props.sv
`timescale 1ns/1ps
`include "instr_exec_defs.vh"
module instr_exec_props (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        busy_q,
  input logic        global_irq_enable_q
);
  logic        wr_q;
  logic        rd_q;
  logic [11:0] a_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      a_q  <= 12'h0;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      a_q  <= haddr[11:0];
    end
  end
  // A write in the busy cycle is dropped, so it cannot start anything.
  wire go  = wr_q && a_q == `OFS_INSTR && !busy_q;
  wire irq = go && hwdata[13:0] == `ENC_RET_IRQ;
  wire ret = irq || (go && hwdata[13:10] == 4'hd);
  wire st  = wr_q && a_q == `OFS_STATUS && !busy_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_ret_two: assert property (ret |=> busy_q ##1 !busy_q) else $error("return not two cycles");
  a_busy_cause: assert property ($rose(busy_q) |-> $past(ret)) else $error("busy without return");
  a_irq_enable: assert property (irq |=> global_irq_enable_q) else $error("enable not set");
  a_enable_rise: assert property ($rose(global_irq_enable_q) |-> $past(irq || (st && hwdata[1])))
    else $error("enable rose without cause");
  a_enable_fall: assert property ($fell(global_irq_enable_q) |-> $past(st)) else $error("enable fell");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside data phase");
  a_byte_regs: assert property (rd_q && (a_q == `OFS_ACC || a_q == `OFS_OPTION) |-> hrdata[31:8] == 24'h0)
    else $error("register wider than a byte");
  a_busy_one: assert property (busy_q |=> !busy_q) else $error("busy held too long");
endmodule
bind instruction_subset_exec instr_exec_props props_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .busy_q, .global_irq_enable_q);

// ===== dv/instruction_subset_exec_test.sv
`timescale 1ns/1ps
`include "instr_exec_defs.vh"
module instruction_subset_exec_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy_q, global_irq_enable_q, rd_ph, d, z, global_irq_enable;
  logic [31:0] haddr, hwdata, hrdata, lfsr, rv, sv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  acc, fv;
  logic [6:0]  n;
  logic [31:0] exp_q[$];
  int          n_mismatch, check_count;
  instruction_subset_exec dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .busy_q, .global_irq_enable_q);
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task close_out;
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // The slave has no wait states today, but the bound keeps a stuck bus from hanging the run.
  task hwait;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1 && k <= 50) begin
      k++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'h1) begin
      n_mismatch++;
      close_out;
    end
  endtask
  task xf(input logic [11:0] a, input logic w, input logic [31:0] dt);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwait;
    htrans <= 2'h0;
    hwdata <= dt;
    hwait;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] dt);
    xf(a, 1'h1, dt);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xf(a, 1'h0, 32'h0);
  endtask
  always @(posedge hclk) begin
    if (rd_ph) cmp(exp_q.pop_front(), hrdata);
    rd_ph <= hsel & hreadyout & htrans[1] & !hwrite;
  end
  initial begin
    {hwrite, haddr, hwdata, htrans, rd_ph, z, global_irq_enable} = 0;
    hsel = 1'h1;
    hsize = 3'h2;
    hresetn = 1'h0;
    lfsr = 32'h7d48de65;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    rd(`OFS_OPTION, 32'hff);
    rd(`OFS_STATUS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rv = rnd();
      n = rv[14:8];
      d = rv[15];
      acc = (i == 0) ? 8'h0 : rv[23:16];
      fv = (i == 0) ? 8'h0 : rv[31:24];
      wr(`OFS_ACC, {24'h0, acc});
      wr(`OFS_FILE_BASE + {n, 2'h0}, {24'h0, fv});
      wr(`OFS_INSTR, {18'h0, `OP_OR_ACC, d, n});
      z = (acc | fv) == 8'h0;
      if (d) fv = acc | fv;
      else acc = acc | fv;
      wr(`OFS_INSTR, {18'h0, `OP_MOVE_FILE, ~d, n});
      z = fv == 8'h0;
      if (d) acc = fv;
      rd(`OFS_ACC, {24'h0, acc});
      rd(`OFS_FILE_BASE + {n, 2'h0}, {24'h0, fv});
      rd(`OFS_STATUS, {30'h0, global_irq_enable, z});
      wr(`OFS_INSTR, {18'h0, 7'h01, n});
      wr(`OFS_INSTR, {18'h0, `ENC_OPT_LOAD});
      rd(`OFS_FILE_BASE + {n, 2'h0}, {24'h0, acc});
      rd(`OFS_OPTION, {24'h0, acc});
      rd(`OFS_STATUS, {30'h0, global_irq_enable, z});
      sv = rnd();
      wr(`OFS_STACK_TOP, {19'h0, sv[12:0]});
      wr(`OFS_INSTR, {18'h0, `ENC_RET_IRQ});
      @(posedge hclk);
      global_irq_enable = 1'h1;
      rd(`OFS_PC, {19'h0, sv[12:0]});
      rd(`OFS_STATUS, {30'h0, global_irq_enable, z});
      wr(`OFS_INSTR, {18'h0, 4'hd, sv[21:20], sv[31:24]});
      @(posedge hclk);
      rd(`OFS_ACC, {24'h0, sv[31:24]});
      rd(`OFS_PC, {19'h0, sv[12:0]});
      wr(`OFS_STATUS, {31'h0, z});
      global_irq_enable = 1'h0;
    end
    // An unknown word raises the illegal flag; the next executed word, a no-op, clears it.
    wr(`OFS_INSTR, {18'h0, 14'h3fff});
    rd(`OFS_STATUS, {28'h0, 1'h1, 2'h0, z});
    wr(`OFS_INSTR, 32'h0000_0060);
    rd(`OFS_STATUS, {31'h0, z});
    rd(`OFS_PC, {19'h0, sv[12:0] + 13'h0002});
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 32'h0);
    close_out;
  end
endmodule
